// ### logic/p10l_top.sv
// PHY link control: Manchester coding, collision and carrier sense, negotiation and low power idle.
//
// Decided for this implementation: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "p10l_defs.svh"

// Functional notes
// - Manchester line code at 10 Mb/s.
// - Serialize transmit nibbles, then Manchester encode.
// - Manchester decode, regroup into receive nibbles.
// - Half duplex: both paths active means collision.
// - Collision drives the collision output.
// - No collision indication in full duplex.
// - Half duplex carrier on transmit or receive.
// - Full duplex carrier on receive only.
// - Advertise, acknowledge, reject unshared modes.
// - Fixed priority picks one common mode.
// - Parallel detect from received signal only.
// - Matching detected technology brings link up.
// - Idle link at 100 Mb/s enters transmit LPI.
// - Receive LPI only after partner LPI symbols.
// - Transmit and receive LPI are independent.
// - Energy saving only when both ends advertise.
// - Status bit 12 shows energy saving on.
// - J/K become preamble, T/R are stripped.
module p10l_top import p10l_pkg::*; #(
   parameter int NIB_W = 4,
   parameter int BUF_DEPTH = 2,
   parameter logic [15:0] PD_WAIT = 16'h0400
) (
   input wire logic mclk, // 20 MHz clock
   input wire logic arst_n, // asynchronous reset, active low
   input wire logic [7:0] reg_addr, // register byte address
   input wire logic [15:0] reg_wdata, // register write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [15:0] reg_rdata, // read data, cycle after the strobe
   input wire logic tx_valid, // transmit nibble offered by the MAC
   input wire logic [NIB_W-1:0] txd, // transmit nibble
   output logic tx_ready, // buffer accepts the nibble
   output logic rx_dv, // receive nibble strobe
   output logic [NIB_W-1:0] rxd, // receive nibble
   output logic col, // collision
   output logic crs, // carrier sense
   output logic tx_line, // Manchester half bit to the line driver
   output logic tx_line_en, // line driver enable
   input wire logic rx_act, // 10 Mb/s receive frame in progress
   input wire logic rx_line, // 10 Mb/s Manchester half bit from the line
   input wire logic sym_valid, // 100 Mb/s code group strobe
   input wire logic [4:0] sym, // 100 Mb/s aligned code group
   output logic tx100_valid, // 100 Mb/s transmit nibble strobe
   output logic [NIB_W-1:0] tx100_nib, // 100 Mb/s transmit nibble
   input wire logic sig_10, // link pulses of 10 Mb/s seen
   input wire logic sig_100, // 100 Mb/s idle stream seen
   input wire logic lp_page_valid, // partner ability page received
   input wire logic [4:0] lp_page, // partner ability page
   input wire logic lp_ack, // partner acknowledged our page
   output logic an_adv_valid, // sending our ability page
   output logic [4:0] an_adv_page, // our ability page
   output logic an_ack, // acknowledging partner page
   input wire logic rx_lpi_sym, // partner LPI symbols decoded
   output logic lpi_tx, // transmitter in low power idle
   output logic lpi_rx // receiver in low power idle
);

   initial begin
      if (NIB_W != 4) $error("p10l_top: nibble width must be 4");
      if (BUF_DEPTH != 2 && BUF_DEPTH != 4) $error("p10l_top: depth must be 2 or 4");
   end

   localparam int PW = $clog2(BUF_DEPTH);

   logic rst_meta_r, rst_n_r;
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   function automatic p10l_mode_t pick(input logic [3:0] c);
      p10l_mode_t m;
      m = '0;
      if (c[`P10L_AB_100F]) m = '{1'b1, 1'b1, 1'b1};
      else if (c[`P10L_AB_100H]) m = '{1'b1, 1'b1, 1'b0};
      else if (c[`P10L_AB_10F]) m = '{1'b1, 1'b0, 1'b1};
      else if (c[`P10L_AB_10H]) m = '{1'b1, 1'b0, 1'b0};
      return m;
   endfunction : pick

   function automatic logic [4:0] dec4b(input logic [4:0] s);
      logic [4:0] r;
      r = 5'h00;
      unique case (s)
         5'h1e: r = 5'h10;  5'h09: r = 5'h11;  5'h14: r = 5'h12;  5'h15: r = 5'h13;
         5'h0a: r = 5'h14;  5'h0b: r = 5'h15;  5'h0e: r = 5'h16;  5'h0f: r = 5'h17;
         5'h12: r = 5'h18;  5'h13: r = 5'h19;  5'h16: r = 5'h1a;  5'h17: r = 5'h1b;
         5'h1a: r = 5'h1c;  5'h1b: r = 5'h1d;  5'h1c: r = 5'h1e;  5'h1d: r = 5'h1f;
         default: r = 5'h00;
      endcase
      return r; // Bit 4 marks a data code group; idle and invalid groups are dropped.
   endfunction : dec4b

   ////////////////////////////////////////////////////////////////////////////////
   // Registers.
   logic [2:0] ctrl_r;
   logic [4:0] adv_r, lpa_r;
   logic [15:0] idle_thr_r;
   logic link_r, spd100_r, full_r, by_an_r, by_pd_r, eee_on_r, lpi_tx_r, lpi_rx_r;
   logic [15:0] rdata_r, rd_mux;
   logic restart;
   p10l_an_t an_r;

   assign restart = reg_wr && reg_addr[7:2] == `P10L_IDX_CTRL && reg_addr[1:0] == 2'b00
      && reg_wdata[`P10L_CTRL_RESTART];

   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ctrl_r <= `P10L_CTRL_RST;
         adv_r <= `P10L_ADV_RST;
         idle_thr_r <= `P10L_IDLE_RST;
      end else if (reg_wr && reg_addr[1:0] == 2'b00) begin
         unique case (reg_addr[7:2])
            `P10L_IDX_CTRL: ctrl_r <= reg_wdata[2:0];
            `P10L_IDX_ADV: adv_r <= reg_wdata[4:0];
            `P10L_IDX_IDLE: idle_thr_r <= reg_wdata;
            default: ;
         endcase
      end
   end

   always_comb begin
      rd_mux = 16'h0000;
      if (reg_addr[1:0] == 2'b00) begin
         unique case (reg_addr[7:2])
            `P10L_IDX_CTRL: rd_mux = {13'h0000, ctrl_r};
            `P10L_IDX_STAT: rd_mux = {11'h000, by_pd_r, by_an_r, full_r, spd100_r, link_r};
            `P10L_IDX_ADV: rd_mux = {11'h000, adv_r};
            `P10L_IDX_LPA: rd_mux = {11'h000, lpa_r};
            `P10L_IDX_IDLE: rd_mux = idle_thr_r;
            `P10L_IDX_EEE: begin
               rd_mux[`P10L_EEE_ON_BIT] = eee_on_r;
               rd_mux[`P10L_EEE_RXLPI_BIT] = lpi_rx_r;
               rd_mux[`P10L_EEE_TXLPI_BIT] = lpi_tx_r;
            end
            default: rd_mux = 16'h0000;
         endcase
      end
   end

   // Read data stand for one cycle only, so a stale word is never mistaken for a fresh one.
   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) rdata_r <= 16'h0000;
      else rdata_r <= reg_rd ? rd_mux : 16'h0000;
   end
   assign reg_rdata = rdata_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Auto-negotiation, parallel detection and forced modes.
   logic [15:0] an_cnt_r;
   p10l_mode_t res, pd_mode;

   assign res = pick(adv_r[3:0] & lpa_r[3:0]);
   always_comb begin
      pd_mode = '0;
      if (sig_100 && (adv_r[`P10L_AB_100H] || adv_r[`P10L_AB_100F])) begin
         pd_mode = '{1'b1, 1'b1, 1'b0};
      end else if (sig_10 && (adv_r[`P10L_AB_10H] || adv_r[`P10L_AB_10F])) begin
         pd_mode = '{1'b1, 1'b0, 1'b0};
      end
   end

   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         an_r <= P10L_AN_IDLE;
         an_cnt_r <= 16'h0000;
         lpa_r <= 5'h00;
         link_r <= 1'b0;
         spd100_r <= 1'b0;
         full_r <= 1'b0;
         by_an_r <= 1'b0;
         by_pd_r <= 1'b0;
      end else if (restart) begin
         an_r <= P10L_AN_IDLE;
         link_r <= 1'b0;
      end else begin
         unique case (an_r)
            P10L_AN_IDLE: begin
               an_cnt_r <= 16'h0000;
               by_an_r <= 1'b0;
               by_pd_r <= 1'b0;
               if (ctrl_r[`P10L_CTRL_AN_EN]) begin
                  an_r <= P10L_AN_ADV;
               end else if (ctrl_r[`P10L_CTRL_F100] ? sig_100 : sig_10) begin
                  an_r <= P10L_AN_LINK;
                  link_r <= 1'b1;
                  spd100_r <= ctrl_r[`P10L_CTRL_F100];
                  full_r <= ctrl_r[`P10L_CTRL_FFULL];
               end
            end
            P10L_AN_ADV: begin
               if (lp_page_valid) begin
                  lpa_r <= lp_page;
                  an_r <= P10L_AN_ACK;
               end else if ((sig_10 || sig_100) && an_cnt_r >= PD_WAIT) begin
                  an_r <= P10L_AN_PD;
               end else begin
                  an_cnt_r <= (sig_10 || sig_100) ? an_cnt_r + 16'h0001 : 16'h0000;
               end
            end
            P10L_AN_ACK: begin
               if (lp_ack) begin
                  if (res.found) begin
                     an_r <= P10L_AN_LINK;
                     link_r <= 1'b1;
                     spd100_r <= res.speed100;
                     full_r <= res.full;
                     by_an_r <= 1'b1;
                  end else begin
                     an_r <= P10L_AN_IDLE;
                  end
               end
            end
            P10L_AN_PD: begin
               an_cnt_r <= 16'h0000;
               lpa_r <= 5'h00;
               if (pd_mode.found) begin
                  an_r <= P10L_AN_LINK;
                  link_r <= 1'b1;
                  spd100_r <= pd_mode.speed100;
                  full_r <= 1'b0;
                  by_pd_r <= 1'b1;
               end else begin
                  an_r <= P10L_AN_ADV;
               end
            end
            P10L_AN_LINK: begin
               if (!(spd100_r ? sig_100 : sig_10)) begin
                  an_r <= P10L_AN_IDLE;
                  link_r <= 1'b0;
               end
            end
            default: an_r <= P10L_AN_IDLE;
         endcase
      end
   end

   assign an_adv_valid = an_r == P10L_AN_ADV;
   assign an_ack = an_r == P10L_AN_ACK;
   assign an_adv_page = adv_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Transmit buffer of BUF_DEPTH entries, two by default or four, between the MAC and the line coders.
   logic [NIB_W-1:0] buf_mem [BUF_DEPTH];
   logic [PW-1:0] wp_r, rp_r;
   logic [PW:0] cnt_r;
   logic buf_valid, buf_pop, buf_push;

   assign tx_ready = cnt_r != BUF_DEPTH[PW:0];
   assign buf_valid = cnt_r != '0;
   assign buf_push = tx_valid && tx_ready;

   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (buf_push) wp_r <= wp_r + 1'b1;
         if (buf_pop) rp_r <= rp_r + 1'b1;
         cnt_r <= cnt_r + (PW+1)'(buf_push) - (PW+1)'(buf_pop);
      end
   end

   always_ff @(posedge mclk) begin
      if (buf_push) buf_mem[wp_r] <= txd;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Transmit: nibble serializer with Manchester encoder, or 100 Mb/s nibble stream.
   logic [NIB_W-1:0] sh_r;
   logic [1:0] bit_r;
   logic half_r, ser_busy_r, tx_act;

   // At 10 Mb/s a new nibble is taken only once the last half bit is out, so the line never stutters.
   assign buf_pop = buf_valid && link_r && !lpi_tx_r && (spd100_r || !ser_busy_r ||
      (bit_r == 2'b11 && half_r));
   assign tx_act = ser_busy_r || buf_valid || tx100_valid;

   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sh_r <= '0;
         bit_r <= 2'b00;
         half_r <= 1'b0;
         ser_busy_r <= 1'b0;
         tx_line <= 1'b0;
         tx_line_en <= 1'b0;
      end else if (buf_pop && !spd100_r) begin
         sh_r <= buf_mem[rp_r];
         bit_r <= 2'b00;
         half_r <= 1'b0;
         ser_busy_r <= 1'b1;
         tx_line <= ~buf_mem[rp_r][0];
         tx_line_en <= 1'b1;
      end else if (ser_busy_r && !half_r) begin
         half_r <= 1'b1;
         tx_line <= sh_r[bit_r];
      end else if (ser_busy_r && bit_r != 2'b11) begin
         half_r <= 1'b0;
         bit_r <= bit_r + 2'b01;
         tx_line <= ~sh_r[bit_r + 2'b01];
      end else begin
         ser_busy_r <= 1'b0;
         half_r <= 1'b0;
         tx_line <= 1'b0;
         tx_line_en <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         tx100_valid <= 1'b0;
         tx100_nib <= '0;
      end else begin
         tx100_valid <= buf_pop && spd100_r;
         tx100_nib <= (buf_pop && spd100_r) ? buf_mem[rp_r] : '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Receive: Manchester decoder at 10 Mb/s, code group decoder at 100 Mb/s.
   logic [2:0] rx_pos_r;
   logic first_r;
   logic [NIB_W-1:0] acc_r;
   logic [4:0] d4;
   logic rx_busy;

   assign d4 = dec4b(sym);
   assign rx_busy = spd100_r ? sym_valid : rx_act;

   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rx_pos_r <= 3'b000;
         first_r <= 1'b0;
         acc_r <= '0;
         rx_dv <= 1'b0;
         rxd <= '0;
      end else begin
         rx_dv <= 1'b0;
         if (spd100_r) begin
            rx_pos_r <= 3'b000;
            if (sym_valid && (sym == `P10L_SYM_J || sym == `P10L_SYM_K)) begin
               rx_dv <= 1'b1;
               rxd <= `P10L_PREAMBLE;
            end else if (sym_valid && d4[4]) begin
               rx_dv <= 1'b1;
               rxd <= d4[3:0];
            end
         end else if (!rx_act) begin
            rx_pos_r <= 3'b000;
         end else begin
            rx_pos_r <= rx_pos_r + 3'b001;
            if (!rx_pos_r[0]) begin
               first_r <= rx_line;
            end else begin
               // Bit value is the second half; an invalid pair keeps the second half too.
               acc_r[rx_pos_r[2:1]] <= rx_line;
               if (rx_pos_r == 3'b111) begin
                  rx_dv <= 1'b1;
                  rxd <= {rx_line, acc_r[2:0]};
               end
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Collision and carrier sense.
   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         col <= 1'b0;
         crs <= 1'b0;
      end else begin
         col <= link_r && !full_r && tx_act && rx_busy;
         crs <= full_r ? rx_busy : (tx_act || rx_busy);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Low power idle; each path keeps its own state so they move independently.
   logic [15:0] idle_cnt_r;
   logic eee_ok;

   assign eee_ok = link_r && spd100_r && by_an_r && adv_r[`P10L_AB_EEM] && lpa_r[`P10L_AB_EEM];

   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) eee_on_r <= 1'b0;
      else eee_on_r <= eee_ok;
   end

   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) begin
         idle_cnt_r <= 16'h0000;
         lpi_tx_r <= 1'b0;
      end else if (!eee_on_r || tx_valid || tx_act) begin
         idle_cnt_r <= 16'h0000;
         lpi_tx_r <= 1'b0;
      end else if (idle_cnt_r >= idle_thr_r) begin
         lpi_tx_r <= 1'b1;
      end else begin
         idle_cnt_r <= idle_cnt_r + 16'h0001;
      end
   end

   always_ff @(posedge mclk or negedge rst_n_r) begin
      if (!rst_n_r) lpi_rx_r <= 1'b0;
      else lpi_rx_r <= eee_on_r && rx_lpi_sym;
   end

   assign lpi_tx = lpi_tx_r;
   assign lpi_rx = lpi_rx_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks.
   sequence s_pair_start;
      tx_line_en && !spd100_r && !half_r && ser_busy_r;
   endsequence

   sequence s_jk;
      spd100_r && sym_valid && (sym == `P10L_SYM_J || sym == `P10L_SYM_K);
   endsequence

   chk_manch_pair: assert property (@(posedge mclk) disable iff (!rst_n_r)
      s_pair_start |=> tx_line == !$past(tx_line)) else $error("Manchester halves not inverse");
   chk_rx_nib_gap: assert property (@(posedge mclk) disable iff (!rst_n_r)
      (rx_dv && !spd100_r && !$past(spd100_r)) |=> !rx_dv [*7]) else $error("10M nibbles too close");
   chk_col_both: assert property (@(posedge mclk) disable iff (!rst_n_r)
      (link_r && !full_r && tx_act && rx_busy) |=> col) else $error("Collision not flagged");
   chk_col_full_off: assert property (@(posedge mclk) disable iff (!rst_n_r)
      col |-> !$past(full_r)) else $error("Collision in full duplex");
   chk_crs_half: assert property (@(posedge mclk) disable iff (!rst_n_r)
      (!full_r && (tx_act || rx_busy)) |=> crs) else $error("Carrier missing in half duplex");
   chk_crs_full_tx: assert property (@(posedge mclk) disable iff (!rst_n_r)
      (full_r && !rx_busy) |=> !crs) else $error("Carrier on transmit in full duplex");
   chk_an_common: assert property (@(posedge mclk) disable iff (!rst_n_r)
      (an_r == P10L_AN_ACK && lp_ack && !restart) |=> (link_r == res.found)
      && (!link_r || (spd100_r == res.speed100 && full_r == res.full)))
      else $error("Resolved mode not the best common one");
   chk_pd_link: assert property (@(posedge mclk) disable iff (!rst_n_r)
      (an_r == P10L_AN_PD && pd_mode.found && !restart) |=> link_r && by_pd_r && !full_r)
      else $error("Parallel detect did not bring link up");
   chk_lpi_tx_cause: assert property (@(posedge mclk) disable iff (!rst_n_r)
      $rose(lpi_tx_r) |-> $past(eee_on_r) && $past(idle_cnt_r) >= $past(idle_thr_r))
      else $error("Transmit LPI without idle link");
   chk_lpi_rx_cause: assert property (@(posedge mclk) disable iff (!rst_n_r)
      lpi_rx_r |-> $past(rx_lpi_sym) && $past(eee_on_r)) else $error("Receive LPI without symbols");
   chk_eee_gate: assert property (@(posedge mclk) disable iff (!rst_n_r)
      eee_on_r |-> $past(adv_r[`P10L_AB_EEM] && lpa_r[`P10L_AB_EEM] && spd100_r))
      else $error("Energy saving on without both ends");
   chk_jk_pre: assert property (@(posedge mclk) disable iff (!rst_n_r)
      s_jk |=> rx_dv && rxd == `P10L_PREAMBLE) else $error("Delimiter not replaced by preamble");

endmodule : p10l_top

// ### logic/p10l_defs.svh
// Register offsets, field positions, reset values and code points for the PHY link control block.
`ifndef P10L_DEFS_SVH
`define P10L_DEFS_SVH

// Register indices; the byte address is four times the index.
`define P10L_IDX_CTRL 6'h00
`define P10L_IDX_STAT 6'h01
`define P10L_IDX_ADV 6'h04
`define P10L_IDX_LPA 6'h05
`define P10L_IDX_IDLE 6'h06
`define P10L_IDX_EEE 6'h1d

// Control register fields and reset value.
`define P10L_CTRL_AN_EN 0
`define P10L_CTRL_F100 1
`define P10L_CTRL_FFULL 2
`define P10L_CTRL_RESTART 3
`define P10L_CTRL_RST 3'h1

// Ability page layout: bit 0 10 half, 1 10 full, 2 100 half, 3 100 full, 4 energy efficient.
`define P10L_AB_10H 0
`define P10L_AB_10F 1
`define P10L_AB_100H 2
`define P10L_AB_100F 3
`define P10L_AB_EEM 4
`define P10L_ADV_RST 5'h1f

// Energy efficient status register fields.
`define P10L_EEE_ON_BIT 12
`define P10L_EEE_RXLPI_BIT 9
`define P10L_EEE_TXLPI_BIT 8

// Idle threshold before transmit low power idle, in clock cycles.
`define P10L_IDLE_RST 16'h0100

// Code groups of the 100 Mb/s receive path.
`define P10L_SYM_J 5'h18
`define P10L_SYM_K 5'h11
`define P10L_SYM_T 5'h0d
`define P10L_SYM_R 5'h07
`define P10L_PREAMBLE 4'h5

`endif

// ### logic/p10l_pkg.sv
// Types shared by the PHY link control block.
package p10l_pkg;

   typedef enum logic [2:0] {
      P10L_AN_IDLE = 3'b000,
      P10L_AN_ADV = 3'b001,
      P10L_AN_ACK = 3'b010,
      P10L_AN_PD = 3'b011,
      P10L_AN_LINK = 3'b100
   } p10l_an_t;

   typedef struct packed {
      logic found;
      logic speed100;
      logic full;
   } p10l_mode_t;

endpackage : p10l_pkg

// ### sim/p10l_partner.sv
// Remote link partner model: ability pages, line presence and receive streams.
`timescale 1ns/1ps
module p10l_partner (
   input wire logic mclk, // clock
   input wire logic [1:0] mode, // 0 negotiates, 1 plain 100 Mb/s signal
   input wire logic [4:0] page, // partner ability page
   input wire logic an_adv_valid, // device page on the wire
   input wire logic an_ack, // device acknowledges
   output logic lp_page_valid, // page strobe
   output logic [4:0] lp_page, // page
   output logic lp_ack, // acknowledge
   output logic sig_10, // 10 Mb/s signal present
   output logic sig_100, // 100 Mb/s signal present
   output logic rx_act, // 10 Mb/s frame
   output logic rx_line, // Manchester half bit
   output logic sym_valid, // code group strobe
   output logic [4:0] sym, // code group
   output logic rx_lpi_sym // LPI symbols
);
   logic busy = 1'b0;
   initial begin
      {lp_page_valid, lp_page, lp_ack, sig_10, sig_100} = '0;
      {rx_act, rx_line, sym_valid, sym, rx_lpi_sym} = '0;
   end
   always @(posedge mclk) begin
      lp_page_valid <= (mode == 2'h0) && an_adv_valid && !lp_page_valid;
      lp_page <= an_adv_valid ? page : ~page;
      lp_ack <= an_ack || (lp_ack && !an_adv_valid);
      sig_100 <= (mode == 2'h1) || (lp_ack && (page[3:2] != 2'h0));
      sig_10 <= lp_ack && (page[3:2] == 2'h0) && (page[1:0] != 2'h0);
      // Idle lines keep moving so a stale value can never pass for data.
      if (!busy) begin
         rx_line <= ~rx_line;
         sym <= ~sym;
      end
   end
   task automatic send_10(input logic [3:0] n);
      @(negedge mclk) busy = 1'b1;
      for (int i = 0; i < 8; i++) begin
         @(posedge mclk);
         rx_act <= 1'b1;
         rx_line <= n[i/2] ^ ~i[0];
      end
      @(posedge mclk);
      rx_act <= 1'b0;
      @(negedge mclk) busy = 1'b0;
   endtask : send_10
   task automatic send_sym(input logic [4:0] s);
      @(negedge mclk) busy = 1'b1;
      @(posedge mclk);
      sym_valid <= 1'b1;
      sym <= s;
      @(posedge mclk);
      sym_valid <= 1'b0;
      @(negedge mclk) busy = 1'b0;
   endtask : send_sym
   task automatic set_lpi(input logic v);
      @(posedge mclk);
      rx_lpi_sym <= v;
   endtask : set_lpi
endmodule : p10l_partner

// ### sim/tb_top.sv
// Self-checking bench for the PHY link control block.
`timescale 1ns/1ps
module tb_top;
   logic mclk = 1'b0, arst_n = 1'b0, reg_wr, reg_rd, tx_valid;
   logic [7:0] reg_addr, line_sh = 8'h00;
   logic [15:0] reg_wdata, reg_rdata;
   logic [3:0] txd, rxd, tx100_nib, last_rx = 4'h0, last_tx = 4'h0;
   logic [1:0] pmode = 2'h0;
   logic [4:0] ppage = 5'h1f, lp_page, sym, an_adv_page;
   logic tx_ready, rx_dv, col, crs, tx_line, tx_line_en, rx_act, rx_line, sym_valid;
   logic tx100_valid, sig_10, sig_100, lp_page_valid, lp_ack, an_adv_valid, an_ack;
   logic rx_lpi_sym, lpi_tx, lpi_rx, col_seen = 1'b0, crs_seen = 1'b0;
   int err_count = 0, checks_done = 0, rx_cnt = 0, cyc = 0;
   p10l_top #(.PD_WAIT(16'h0040)) i_p10l_top (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .tx_valid, .txd, .tx_ready, .rx_dv, .rxd, .col, .crs, .tx_line,
      .tx_line_en, .rx_act, .rx_line, .sym_valid, .sym, .tx100_valid, .tx100_nib, .sig_10,
      .sig_100, .lp_page_valid, .lp_page, .lp_ack, .an_adv_valid, .an_adv_page, .an_ack,
      .rx_lpi_sym, .lpi_tx, .lpi_rx);
   p10l_partner i_p10l_partner (.mclk, .mode(pmode), .page(ppage), .an_adv_valid, .an_ack,
      .lp_page_valid, .lp_page, .lp_ack, .sig_10, .sig_100, .rx_act, .rx_line, .sym_valid,
      .sym, .rx_lpi_sym);
   initial begin
      forever #25 mclk = ~mclk;
   end
   ////////////////////////////////////////////////////////////////////////////////////////
   // Monitors sample at the edge, so they see registered outputs before they move.
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (col === 1'b1) col_seen <= 1'b1;
      if (crs === 1'b1) crs_seen <= 1'b1;
      if (rx_dv === 1'b1) begin
         rx_cnt <= rx_cnt + 1;
         last_rx <= rxd;
      end
      if (tx100_valid === 1'b1) last_tx <= tx100_nib;
      if (tx_line_en === 1'b1) line_sh <= {line_sh[6:0], tx_line};
      if (cyc == 6000) begin
         err_count++;
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : final_report
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask : rd
   task automatic rchk(input string nm, input logic [7:0] a, input logic [15:0] e);
      logic [15:0] v;
      rd(a, v);
      chk(nm, e, v);
   endtask : rchk
   task automatic poll(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] v;
      for (int k = 0; k < 100; k++) begin
         rd(a, v);
         if (v === e) break;
      end
      chk("status", e, v);
   endtask : poll
   task automatic push(input logic [3:0] n);
      @(posedge mclk);
      tx_valid <= 1'b1;
      txd <= n;
      #1;
      for (int k = 0; k < 50 && tx_ready !== 1'b1; k++) @(posedge mclk) #1;
      @(posedge mclk);
      tx_valid <= 1'b0;
   endtask : push
   task automatic clr();
      @(negedge mclk);
      col_seen = 1'b0;
      crs_seen = 1'b0;
   endtask : clr
   function automatic logic [7:0] man(input logic [3:0] n);
      logic [7:0] e;
      e = 8'h00;
      for (int i = 0; i < 4; i++) e = {e[5:0], ~n[i], n[i]};
      return e;
   endfunction : man
   ////////////////////////////////////////////////////////////////////////////////////////
   initial begin
      {reg_wr, reg_rd, tx_valid, reg_addr, reg_wdata, txd} = '0;
      repeat (8) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      rchk("adv", 8'h10, 16'h001f);
      rchk("idle", 8'h18, 16'h0100);
      rchk("unmapped", 8'h08, 16'h0000);
      poll(8'h04, 16'h000f);
      rchk("lpa", 8'h14, 16'h001f);
      rchk("eee", 8'h74, 16'h1000);
      chk("advpage", 16'h001f, {11'h0, an_adv_page});
      $display("test negotiate done");
      clr();
      push(4'h3);
      repeat (4) @(posedge mclk);
      chk("tx100", 16'h0003, {12'h0, last_tx});
      chk("full tx", 16'h0000, {14'h0, col_seen, crs_seen});
      i_p10l_partner.send_sym(5'h18);
      i_p10l_partner.send_sym(5'h09);
      chk("pre", 16'h0015, {rx_cnt[11:0], last_rx});
      i_p10l_partner.send_sym(5'h0d);
      repeat (3) @(posedge mclk);
      chk("rx100", 16'h0021, {rx_cnt[11:0], last_rx});
      chk("full rx", 16'h0001, {14'h0, col_seen, crs_seen});
      $display("test 100 data done");
      wr(8'h18, 16'h0010);
      for (int k = 0; k < 80 && lpi_tx !== 1'b1; k++) @(posedge mclk);
      chk("lpi", 16'h0002, {14'h0, lpi_tx, lpi_rx});
      i_p10l_partner.set_lpi(1'b1);
      repeat (4) @(posedge mclk);
      rchk("eee lpi", 8'h74, 16'h1300);
      push(4'h7);
      repeat (2) @(posedge mclk);
      chk("lpi exit", 16'h0001, {14'h0, lpi_tx, lpi_rx});
      $display("test low power done");
      i_p10l_partner.set_lpi(1'b0);
      ppage <= 5'h01;
      wr(8'h00, 16'h0009);
      poll(8'h04, 16'h0009);
      rchk("eee off", 8'h74, 16'h0000);
      clr();
      fork
         push(4'ha);
         i_p10l_partner.send_10(4'h6);
      join
      repeat (12) @(posedge mclk);
      chk("line", {8'h0, man(4'ha)}, {8'h0, line_sh});
      chk("rx10", 16'h0036, {rx_cnt[11:0], last_rx});
      chk("half", 16'h0003, {14'h0, col_seen, crs_seen});
      $display("test 10 half done");
      pmode <= 2'h1;
      wr(8'h00, 16'h0009);
      poll(8'h04, 16'h0013);
      $display("test parallel detect done");
      wr(8'h00, 16'h000e);
      poll(8'h04, 16'h0007);
      rchk("eee forced", 8'h74, 16'h0000);
      wr(8'h11, 16'h0003);
      rchk("odd", 8'h10, 16'h001f);
      arst_n <= 1'b0;
      repeat (2) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (4) @(posedge mclk);
      rchk("ctrl", 8'h00, 16'h0001);
      $display("test forced and reset done");
      final_report();
   end
endmodule : tb_top
